//--- verilog/dds_regs.vh
// Purpose: constants for the modulus extension and source priority block
// Assumes: Avalon-MM word registers, byte address = register index times four
// Notes:   reset values of unprinted registers are zero, except the profile registers, which reset leaves unchanged
// Function
// RULE1: modulus mode reuses the ramp accumulator as an auxiliary accumulator.
// RULE2: output frequency is clock times (tuning word plus numerator/denominator) over 2^32.
// RULE3: auxiliary accumulator wraps at the programmed denominator, not at 2^32.
// RULE4: each auxiliary wrap adds one LSB into the phase accumulator.
// RULE5: tuning word, denominator, numerator come from registers 0x04, 0x05, 0x06.
// RULE6: modulus mode owns frequency; no other source may drive it then.
// RULE7: in modulus mode the ramp cannot sweep phase or amplitude.
// RULE8: software uses profile mode and profile pins for phase in modulus mode.
// RULE9: software needs profile mode plus keying enable for amplitude in modulus mode.
// RULE10: ramp ranks second; unswept parameters stay with profile mode.
// RULE11: profiles rank third and may drive all three parameters.
// RULE12: parallel port ranks lowest, driving only unclaimed parameters.
// RULE13: profile and parallel enables at 0x01[23:22]; profile wins on frequency.
// RULE14: enabled output keying takes precedence for amplitude over every source; the code gives it precedence only with manual keying (0x00[9]) set.
// RULE15: updates happen on a 1/24 rate tick; pins are sampled then.
// RULE16: source selection resolved separately per parameter on every update.
`ifndef DDS_REGS_VH
`define DDS_REGS_VH

// register indices
`define IDX_CTRL1      6'h00
`define IDX_CTRL2      6'h01
`define IDX_FTW        6'h04
`define IDX_MOD_DEN    6'h05
`define IDX_MOD_NUM    6'h06
`define IDX_KEY_AMP    6'h08
`define IDX_RAMP_STEP  6'h09
`define IDX_STATUS     6'h0a
`define IDX_AUX_ACC    6'h0b
`define PROF_REGION    2'h1

// field positions
`define CTRL1_KEY_EN   8
`define CTRL1_KEY_MAN  9
`define CTRL2_PROF_EN  23
`define CTRL2_PAR_EN   22
`define CTRL2_RDST_HI  21
`define CTRL2_RDST_LO  20
`define CTRL2_RAMP_EN  19
`define CTRL2_MOD_EN   18

// reset values
`define CTRL1_RST      32'h00000000
`define CTRL2_RST      32'h00000000
`define WORD_RST       32'h00000000
`define KEY_AMP_RST    12'hfff
`define AMP_FULL       12'hfff

// timing
`define SYNC_DIV       5'h18

// ramp destinations
`define DST_FREQ       2'h0
`define DST_PHASE      2'h1
`define DST_AMP        2'h2

// parallel function codes
`define PF_AMP         2'h0
`define PF_PHASE       2'h1
`define PF_FREQ        2'h2
`define PF_POLAR       2'h3

// source codes
`define SRC_SINGLE     3'h0
`define SRC_MODULUS    3'h1
`define SRC_RAMP       3'h2
`define SRC_PROFILE    3'h3
`define SRC_PARALLEL   3'h4
`define SRC_KEYING     3'h5
`define SRC_FIXED      3'h6

`endif

//--- verilog/profile_mem.v
// Purpose: eight-entry profile store, two registered read ports
// Assumes: one write port with byte enables
// Notes:   port a serves the bus, port b the profile pins
`timescale 1ns/100ps
`default_nettype none
module profile_mem #(
	parameter AW = 3
) (
	// clock and reset
	input  wire          clk_sys,
	input  wire          resetn,
	// write port
	input  wire          we_lo,
	input  wire          we_hi,
	input  wire [AW-1:0] waddr,
	input  wire [3:0]    wbe,
	input  wire [31:0]   wdata,
	// read ports
	input  wire [AW-1:0] raddr_a,
	output reg  [63:0]   rdata_a,
	input  wire [AW-1:0] raddr_b,
	output reg  [63:0]   rdata_b
);
	reg [31:0] lo_mem [0:(1<<AW)-1];
	reg [31:0] hi_mem [0:(1<<AW)-1];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			always @(posedge clk_sys) begin
				if (we_lo && wbe[g])
					lo_mem[waddr][8*g+7:8*g] <= wdata[8*g+7:8*g];
				if (we_hi && wbe[g])
					hi_mem[waddr][8*g+7:8*g] <= wdata[8*g+7:8*g];
			end
		end
	endgenerate

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_a <= 64'h0000000000000000;
			rdata_b <= 64'h0000000000000000;
		end else begin
			rdata_a <= {hi_mem[raddr_a], lo_mem[raddr_a]};
			rdata_b <= {hi_mem[raddr_b], lo_mem[raddr_b]};
		end
	end
endmodule
`default_nettype wire

//--- verilog/dds_mod_priority.v
// Purpose: modulus extension, phase accumulator and per-parameter source priority
// Assumes: clk_sys stands for the sample clock; pins come from outside the domain
// Notes:   parameters update on a tick every SYNC_DIV cycles
`include "dds_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module dds_mod_priority #(
	parameter SYNC_DIV = `SYNC_DIV
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// avalon-mm slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [3:0]  byteenable,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	// device pins
	input  wire [2:0]  profile_select_pins,
	input  wire        ramp_dir_pin,
	input  wire        ramp_hold_pin,
	input  wire [31:0] par_data_pins,
	input  wire [3:0]  par_func_pins,
	// parameters to the synthesizer core
	output reg  [31:0] freq_word,
	output reg  [15:0] phase_word,
	output reg  [11:0] amp_word,
	output reg  [31:0] phase_acc,
	output reg         mod_carry,
	output reg         update_tick
);
	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer i;
		begin
			be_merge = old_v;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					be_merge[8*i+:8] = new_v[8*i+:8];
		end
	endfunction

	function is_prof;
		input [5:0] idx;
		begin
			is_prof = (idx[5:4] == `PROF_REGION);
		end
	endfunction

	// registers
	reg  [31:0] ctrl1_r;
	reg  [31:0] ctrl2_r;
	reg  [31:0] ftw_r;
	reg  [31:0] den_r;
	reg  [31:0] num_r;
	reg  [11:0] key_amp_r;
	reg  [31:0] ramp_step_r;
	reg         stage_r;
	reg  [4:0]  sync_cnt_r;
	reg  [40:0] pin_meta_r;
	reg  [40:0] pin_sync_r;
	reg  [31:0] aux_acc_r;
	reg         mod_prev_r;
	reg  [2:0]  freq_src_r;
	reg  [2:0]  phase_src_r;
	reg  [2:0]  amp_src_r;

	wire [5:0]  idx     = address[7:2];
	wire        wr_go   = write && !waitrequest;
	wire [63:0] mem_a;
	wire [63:0] mem_b;
	wire [31:0] key_amp_wr = be_merge({20'h00000, key_amp_r}, writedata, byteenable);

	wire [2:0]  ps      = pin_sync_r[2:0];
	wire        rdir    = pin_sync_r[3];
	wire        rhold   = pin_sync_r[4];
	wire [3:0]  pfunc   = pin_sync_r[8:5];
	wire [31:0] pdata   = pin_sync_r[40:9];

	wire        key_en  = ctrl1_r[`CTRL1_KEY_EN];
	wire        key_man = ctrl1_r[`CTRL1_KEY_MAN];
	wire        prof_en = ctrl2_r[`CTRL2_PROF_EN];
	wire        par_en  = ctrl2_r[`CTRL2_PAR_EN];
	wire        mod_en  = ctrl2_r[`CTRL2_MOD_EN];
	wire [1:0]  rdst    = ctrl2_r[`CTRL2_RDST_HI:`CTRL2_RDST_LO];
	wire        ramp_on = ctrl2_r[`CTRL2_RAMP_EN] && !mod_en; // [RULE7]
	wire        tick    = (sync_cnt_r == SYNC_DIV - 1);

	wire [31:0] prof_ftw = mem_b[31:0];
	wire [15:0] prof_pow = mem_b[63:48];
	wire [11:0] prof_asf = mem_b[43:32];

	wire        par_f   = par_en && (pfunc[1:0] == `PF_FREQ);
	wire        par_p   = par_en && (pfunc[1:0] == `PF_PHASE || pfunc[1:0] == `PF_POLAR);
	wire        par_a   = par_en && (pfunc[1:0] == `PF_AMP || pfunc[1:0] == `PF_POLAR);
	wire [15:0] par_pv  = (pfunc[1:0] == `PF_POLAR) ? pdata[31:16] : pdata[15:0];

	profile_mem #(
		.AW(3)
	) u_prof (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.we_lo   (wr_go && is_prof(idx) && !idx[0]),
		.we_hi   (wr_go && is_prof(idx) && idx[0]),
		.waddr   (idx[3:1]),
		.wbe     (byteenable),
		.wdata   (writedata),
		.raddr_a (idx[3:1]),
		.rdata_a (mem_a),
		.raddr_b (ps),
		.rdata_b (mem_b)
	);

	// read data mux
	reg [31:0] rd_mux;
	always @* begin
		if (is_prof(idx))
			rd_mux = idx[0] ? mem_a[63:32] : mem_a[31:0];
		else if (idx == `IDX_CTRL1)
			rd_mux = ctrl1_r;
		else if (idx == `IDX_CTRL2)
			rd_mux = ctrl2_r;
		else if (idx == `IDX_FTW)
			rd_mux = ftw_r;
		else if (idx == `IDX_MOD_DEN)
			rd_mux = den_r;
		else if (idx == `IDX_MOD_NUM)
			rd_mux = num_r;
		else if (idx == `IDX_KEY_AMP)
			rd_mux = {20'h00000, key_amp_r};
		else if (idx == `IDX_RAMP_STEP)
			rd_mux = ramp_step_r;
		else if (idx == `IDX_STATUS)
			rd_mux = {23'h000000, amp_src_r, phase_src_r, freq_src_r};
		else if (idx == `IDX_AUX_ACC)
			rd_mux = aux_acc_r;
		else
			rd_mux = 32'h00000000;
	end

	// bus handshake: two edges of wait, then one accepting edge
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			waitrequest <= 1'b1;
			stage_r     <= 1'b0;
			readdata    <= 32'h00000000;
		end else if (waitrequest) begin
			if (read || write) begin
				if (!stage_r) begin
					stage_r <= 1'b1;
				end else begin
					stage_r     <= 1'b0;
					waitrequest <= 1'b0;
					readdata    <= rd_mux;
				end
			end
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// register writes
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl1_r     <= `CTRL1_RST;
			ctrl2_r     <= `CTRL2_RST;
			ftw_r       <= `WORD_RST;
			den_r       <= `WORD_RST;
			num_r       <= `WORD_RST;
			key_amp_r   <= `KEY_AMP_RST;
			ramp_step_r <= `WORD_RST;
		end else if (wr_go) begin
			if (idx == `IDX_CTRL1)
				ctrl1_r <= be_merge(ctrl1_r, writedata, byteenable);
			else if (idx == `IDX_CTRL2)
				ctrl2_r <= be_merge(ctrl2_r, writedata, byteenable); // [RULE13]
			else if (idx == `IDX_FTW)
				ftw_r <= be_merge(ftw_r, writedata, byteenable); // [RULE5]
			else if (idx == `IDX_MOD_DEN)
				den_r <= be_merge(den_r, writedata, byteenable); // [RULE5]
			else if (idx == `IDX_MOD_NUM)
				num_r <= be_merge(num_r, writedata, byteenable); // [RULE5]
			else if (idx == `IDX_KEY_AMP)
				key_amp_r <= key_amp_wr[11:0];
			else if (idx == `IDX_RAMP_STEP)
				ramp_step_r <= be_merge(ramp_step_r, writedata, byteenable);
		end
	end

	// pin synchronisers and update tick
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_meta_r  <= 41'h00000000000;
			pin_sync_r  <= 41'h00000000000;
			sync_cnt_r  <= 5'h00;
			update_tick <= 1'b0;
		end else begin
			pin_meta_r  <= {par_data_pins, par_func_pins, ramp_hold_pin, ramp_dir_pin, profile_select_pins};
			pin_sync_r  <= pin_meta_r;
			sync_cnt_r  <= tick ? 5'h00 : sync_cnt_r + 5'h01; // [RULE15]
			update_tick <= tick;
		end
	end

	// auxiliary accumulator: modulus counter or ramp
	wire [32:0] aux_sum = {1'b0, aux_acc_r} + {1'b0, num_r};
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aux_acc_r  <= 32'h00000000;
			mod_carry  <= 1'b0;
			mod_prev_r <= 1'b0;
		end else begin
			mod_prev_r <= mod_en;
			mod_carry  <= 1'b0;
			if (mod_en && !mod_prev_r) begin
				aux_acc_r <= 32'h00000000;
			end else if (mod_en) begin // [RULE1]
				if (aux_sum >= {1'b0, den_r}) begin
					aux_acc_r <= aux_sum[31:0] - den_r; // [RULE3]
					mod_carry <= 1'b1;
				end else begin
					aux_acc_r <= aux_sum[31:0];
				end
			end else if (ramp_on && tick && !rhold) begin
				aux_acc_r <= rdir ? aux_acc_r + ramp_step_r : aux_acc_r - ramp_step_r;
			end
		end
	end

	// phase accumulator with the modulus carry
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			phase_acc <= 32'h00000000;
		else
			phase_acc <= phase_acc + freq_word + {31'h00000000, mod_carry}; // [RULE4] [RULE2]
	end

	// per-parameter priority, resolved each tick
	reg [31:0] freq_nxt;
	reg [15:0] phase_nxt;
	reg [11:0] amp_nxt;
	reg [2:0]  fsrc_nxt;
	reg [2:0]  psrc_nxt;
	reg [2:0]  asrc_nxt;
	always @* begin
		if (mod_en) begin
			freq_nxt = ftw_r; // [RULE6] [RULE2]
			fsrc_nxt = `SRC_MODULUS;
		end else if (ramp_on && rdst == `DST_FREQ) begin
			freq_nxt = aux_acc_r; // [RULE10]
			fsrc_nxt = `SRC_RAMP;
		end else if (prof_en) begin
			freq_nxt = prof_ftw; // [RULE11] [RULE13]
			fsrc_nxt = `SRC_PROFILE;
		end else if (par_f) begin
			freq_nxt = pdata; // [RULE12]
			fsrc_nxt = `SRC_PARALLEL;
		end else begin
			freq_nxt = prof_ftw;
			fsrc_nxt = `SRC_SINGLE;
		end

		if (ramp_on && rdst == `DST_PHASE) begin
			phase_nxt = aux_acc_r[15:0]; // [RULE10]
			psrc_nxt  = `SRC_RAMP;
		end else if (prof_en) begin
			phase_nxt = prof_pow; // [RULE11]
			psrc_nxt  = `SRC_PROFILE;
		end else if (par_p) begin
			phase_nxt = par_pv; // [RULE12]
			psrc_nxt  = `SRC_PARALLEL;
		end else begin
			phase_nxt = prof_pow;
			psrc_nxt  = `SRC_SINGLE;
		end

		if (!key_en) begin
			amp_nxt  = `AMP_FULL;
			asrc_nxt = `SRC_FIXED;
		end else if (key_man) begin
			amp_nxt  = key_amp_r; // [RULE14]
			asrc_nxt = `SRC_KEYING;
		end else if (ramp_on && rdst == `DST_AMP) begin
			amp_nxt  = aux_acc_r[11:0]; // [RULE10]
			asrc_nxt = `SRC_RAMP;
		end else if (prof_en) begin
			amp_nxt  = prof_asf; // [RULE11]
			asrc_nxt = `SRC_PROFILE;
		end else if (par_a) begin
			amp_nxt  = pdata[11:0]; // [RULE12]
			asrc_nxt = `SRC_PARALLEL;
		end else begin
			amp_nxt  = prof_asf;
			asrc_nxt = `SRC_SINGLE;
		end
	end

	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			freq_word   <= 32'h00000000;
			phase_word  <= 16'h0000;
			amp_word    <= 12'h000;
			freq_src_r  <= `SRC_SINGLE;
			phase_src_r <= `SRC_SINGLE;
			amp_src_r   <= `SRC_SINGLE;
		end else if (tick) begin // [RULE16] [RULE15]
			freq_word   <= freq_nxt;
			phase_word  <= phase_nxt;
			amp_word    <= amp_nxt;
			freq_src_r  <= fsrc_nxt;
			phase_src_r <= psrc_nxt;
			amp_src_r   <= asrc_nxt;
		end
	end
endmodule
`default_nettype wire

//--- testbench/dds_mod_priority_sva.sv
// Purpose: port-level checks for dds_mod_priority
// Assumes: bound to the design top, one clock domain
// Notes:   SYNC_DIV is handed on by the bind
`timescale 1ns/100ps
`default_nettype none
module dds_mod_priority_sva #(
	parameter SYNC_DIV = 24
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        resetn,
	// register bus
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [31:0] readdata,
	// synthesizer parameters
	input wire logic [31:0] freq_word,
	input wire logic [15:0] phase_word,
	input wire logic [11:0] amp_word,
	input wire logic [31:0] phase_acc,
	input wire logic        mod_carry,
	input wire logic        update_tick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic [7:0] gap_r;
	logic       seen_r;
	// cycles since the last update pulse
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			gap_r  <= 8'h00;
			seen_r <= 1'b0;
		end else begin
			gap_r  <= update_tick ? 8'h00 : gap_r + 8'h01;
			seen_r <= seen_r | update_tick;
		end
	end
	sequence s_stall;
		waitrequest [*2] ##1 !waitrequest;
	endsequence
	chk_bus_latency: assert property ($rose(read || write) |-> s_stall)
		else $error("bus answer not two cycles after request");
	chk_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_wait_cause: assert property (!waitrequest |-> read || write)
		else $error("waitrequest low without a request");
	chk_rdata_hold: assert property ($past(resetn) && $changed(readdata) |-> !waitrequest)
		else $error("readdata changed outside a transfer");
	chk_acc_step: assert property ($past(resetn) |->
		phase_acc == $past(phase_acc) + $past(freq_word) + $past(mod_carry))
		else $error("phase accumulator step wrong");
	chk_tick_gap: assert property (update_tick && seen_r |-> gap_r == SYNC_DIV - 1)
		else $error("update pulses not evenly spaced");
	chk_tick_single: assert property (update_tick |=> !update_tick)
		else $error("update pulse longer than one cycle");
	chk_words_hold: assert property ($past(resetn) && !update_tick |->
		$stable({freq_word, phase_word, amp_word}))
		else $error("parameter words changed between updates");
endmodule
bind dds_mod_priority dds_mod_priority_sva #(.SYNC_DIV(SYNC_DIV)) i_dds_mod_priority_sva (
	.clk_sys(clk_sys), .resetn(resetn), .read(read), .write(write), .waitrequest(waitrequest),
	.readdata(readdata), .freq_word(freq_word), .phase_word(phase_word), .amp_word(amp_word),
	.phase_acc(phase_acc), .mod_carry(mod_carry), .update_tick(update_tick)
);
`default_nettype wire

//--- testbench/dds_mod_priority_bench.sv
// Purpose: self-checking bench for dds_mod_priority
// Assumes: update period shortened to 4 cycles
// Notes:   random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module dds_mod_priority_bench;
	localparam int DIV = 4;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [3:0]  byteenable = 4'hf;
	logic [31:0] writedata = 32'h0;
	logic [2:0]  profile_select_pins = 3'h0;
	logic        ramp_dir_pin = 1'b1;
	logic        ramp_hold_pin = 1'b0;
	logic [31:0] par_data_pins = 32'h0;
	logic [3:0]  par_func_pins = 4'h0;
	wire  [31:0] readdata;
	wire         waitrequest;
	wire  [31:0] freq_word;
	wire  [15:0] phase_word;
	wire  [11:0] amp_word;
	wire  [31:0] phase_acc;
	wire         mod_carry;
	wire         update_tick;
	logic [31:0] pf [8];
	logic [15:0] pp [8];
	logic [11:0] pa [8];
	int          err_total = 0;
	int          n_compared = 0;
	always #20 clk_sys = ~clk_sys;
	dds_mod_priority #(.SYNC_DIV(DIV)) i_dds_mod_priority (
		.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.profile_select_pins(profile_select_pins), .ramp_dir_pin(ramp_dir_pin),
		.ramp_hold_pin(ramp_hold_pin), .par_data_pins(par_data_pins), .par_func_pins(par_func_pins),
		.freq_word(freq_word), .phase_word(phase_word), .amp_word(amp_word), .phase_acc(phase_acc),
		.mod_carry(mod_carry), .update_tick(update_tick)
	);
	task give_verdict;
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic wr, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		byteenable <= be;
		writedata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			err_total++;
			give_verdict;
		end
	endtask
	task wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, 4'hf, d, q);
	endtask
	task rd(input logic [5:0] idx, output logic [31:0] q);
		bus(1'b0, idx, 4'hf, 32'h0, q);
	endtask
	// two update pulses, so pins and registers have settled
	task tick2;
		int n;
		int k;
		k = 0;
		for (n = 0; n < 40 && k < 2; n++) begin
			@(posedge clk_sys);
			#1;
			if (update_tick === 1'b1)
				k++;
		end
		if (k < 2) begin
			err_total++;
			give_verdict;
		end
	endtask
	task words(input logic [31:0] fw, input logic [15:0] ph, input logic [11:0] am);
		check("freq_word", freq_word, fw);
		check("phase_word", {16'h0, phase_word}, {16'h0, ph});
		check("amp_word", {20'h0, amp_word}, {20'h0, am});
	endtask
	// a full auxiliary period adds den tuning words and num carries
	function automatic logic [31:0] mod_advance(input logic [31:0] frequency_tuning_word_reg, input logic [31:0] den,
		input logic [31:0] num);
		return frequency_tuning_word_reg * den + num;
	endfunction
	initial begin
		logic [31:0] q, d, frequency_tuning_word_reg, den, num, acc0, f0;
		logic [2:0]  p;
		int          i, f, c;
		void'($urandom(32'he08a1e67));
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		words(32'h0, 16'h0, 12'h0);
		rd(6'h08, q);
		check("key_amp reset", q, 32'hfff);
		for (i = 4; i < 7; i++) begin
			d = $urandom;
			wr(6'(i), d);
			rd(6'(i), q);
			check("word reg", q, d);
		end
		wr(6'h04, 32'h0);
		bus(1'b1, 6'h04, 4'h2, 32'hffffffff, q);
		rd(6'h04, q);
		check("byte lane", q, 32'h0000ff00);
		wr(6'h3f, $urandom);
		rd(6'h3f, q);
		check("unmapped", q, 32'h0);
		for (i = 0; i < 8; i++) begin
			pf[i] = $urandom;
			pp[i] = 16'($urandom);
			pa[i] = 12'($urandom);
			wr(6'h10 + 6'(2 * i), pf[i]);
			wr(6'h11 + 6'(2 * i), {pp[i], 4'h0, pa[i]});
		end
		wr(6'h00, 32'h00000100);
		// parallel alone, then under profiles
		for (i = 0; i < 8; i++) begin
			f = i % 4;
			p = 3'($urandom);
			d = $urandom;
			wr(6'h01, i < 4 ? 32'h00400000 : 32'h00c00000);
			@(posedge clk_sys);
			profile_select_pins <= p;
			par_func_pins <= {2'($urandom), 2'(f)};
			par_data_pins <= d;
			tick2;
			if (i < 4)
				words(f == 2 ? d : pf[p], f == 1 ? d[15:0] : f == 3 ? d[31:16] : pp[p],
					(f == 0 || f == 3) ? d[11:0] : pa[p]);
			else
				words(pf[p], pp[p], pa[p]);
		end
		d = $urandom;
		wr(6'h08, d);
		wr(6'h00, 32'h00000300);
		tick2;
		check("manual keying", {20'h0, amp_word}, {20'h0, d[11:0]});
		wr(6'h00, 32'h0);
		tick2;
		check("full scale", {20'h0, amp_word}, 32'hfff);
		wr(6'h00, 32'h00000100);
		// frequency ramp: up, down, held
		d = 32'h0 + $urandom % 32'h10000;
		wr(6'h09, d);
		wr(6'h01, 32'h00880000);
		for (i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			ramp_dir_pin <= i != 1;
			ramp_hold_pin <= i == 2;
			tick2;
			f0 = freq_word;
			tick2;
			check("ramp freq", freq_word, i == 2 ? f0 : i == 0 ? f0 + 2 * d : f0 - 2 * d);
			check("ramp phase", {16'h0, phase_word}, {16'h0, pp[p]});
		end
		// modulus with ramp, profiles and parallel all asking
		for (i = 0; i < 3; i++) begin
			den = i == 0 ? 32'h5 : i == 1 ? 32'h2 : 32'h2 + $urandom % 199;
			num = i == 0 ? 32'h4 : $urandom % den;
			frequency_tuning_word_reg = i == 0 ? 32'h4ccccccc : $urandom & 32'h7fffffff;
			wr(6'h01, 32'h0);
			wr(6'h04, frequency_tuning_word_reg);
			wr(6'h05, den);
			wr(6'h06, num);
			wr(6'h01, 32'h00dc0000);
			@(posedge clk_sys);
			par_func_pins <= 4'h2;
			tick2;
			words(frequency_tuning_word_reg, pp[p], pa[p]);
			acc0 = phase_acc;
			c = 0;
			repeat (den) begin
				c += int'(mod_carry);
				@(posedge clk_sys);
				#1;
			end
			check("carries", 32'(c), num);
			check("acc advance", phase_acc - acc0, mod_advance(frequency_tuning_word_reg, den, num));
			rd(6'h0a, q);
			check("sources", q, 32'h000000d9);
		end
		// reset in mid-run: registers clear, the profile store keeps its words
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		words(32'h0, 16'h0, 12'h0);
		rd(6'h04, q);
		check("ftw after reset", q, 32'h0);
		tick2;
		words(pf[p], pp[p], 12'hfff);
		give_verdict;
	end
endmodule
`default_nettype wire
